//--- pkg/charger_alert_pkg.sv
/*
 * Constants for the charger alert and system status register bank:
 * command codes, register widths, alert bit positions, masks and resets.
 * Assumes the serial management port decoder delivers one command code
 * and one 16-bit data word per access, already in the MCLK_I domain.
 */
package charger_alert_pkg;

    // command codes of the serial management port
    localparam logic [7:0] CMD_STATE_ALERT  = 8'h37;
    localparam logic [7:0] CMD_STATUS_ALERT = 8'h38;
    localparam logic [7:0] CMD_SYS_STATUS   = 8'h39;

    // widths
    localparam int DATA_W     = 16;
    localparam int STATE_W    = 13;
    localparam int STATUS_W   = 6;
    localparam int SYS_W      = 9;
    localparam int SYS_LOW_W  = 7;
    localparam int IDX_W      = 4;
    localparam int STAT_IDX_W = 3;

    // charger state alert bit positions
    localparam int BIT_DETECT_FAILED  = 12;
    localparam int BIT_DETECTION      = 11;
    localparam int BIT_ABSORB         = 9;
    localparam int BIT_SUSPENDED      = 8;
    localparam int BIT_CURRENT_THEN_VOLTAGE_PHASE = 6;
    localparam int BIT_NTC_PAUSE      = 5;
    localparam int BIT_TIMER_TERM     = 4;
    localparam int BIT_LOW_CURR_TERM  = 3;
    localparam int BIT_MAX_TIME_FAULT = 2;
    localparam int BIT_BAT_MISSING    = 1;
    localparam int BIT_BAT_SHORT      = 0;

    // charge status alert bit positions
    localparam int BIT_ILIM_LOOP      = 5;
    localparam int BIT_THERMAL_REG    = 4;
    localparam int BIT_UV_CURR_LIMIT  = 3;
    localparam int BIT_IIN_LIMIT      = 2;
    localparam int BIT_CONST_CURRENT  = 1;
    localparam int BIT_CONST_VOLTAGE  = 0;

    // system status bit positions
    localparam int BIT_SYS_CHG_ACTIVE = 8;
    localparam int BIT_SYS_CELL_ERR   = 7;

    // implemented alert bits; bits 10, 9 and 7 of the state register
    // have no alert and always read zero
    localparam logic [STATE_W-1:0]  STATE_ALERT_MASK  = 13'h197F;
    localparam logic [STATUS_W-1:0] STATUS_ALERT_MASK = 6'h3F;

    // reset values
    localparam logic [STATE_W-1:0]  STATE_RST  = 13'h0000;
    localparam logic [STATUS_W-1:0] STATUS_RST = 6'h00;
    localparam logic [SYS_W-1:0]    SYS_RST    = 9'h000;
    localparam logic [DATA_W-1:0]   DATA_RST   = 16'h0000;

endpackage

//--- hdl/alert_latch.sv
/*
 * One sticky alert register: per-bit enable gating, edge-triggered set,
 * write-zero clear and clear on disable.
 * Assumes cond_i and en_i come from logic on the same clock.
 */
`timescale 1ns/1ps
module alert_latch #(
    parameter int            W    = 1,
    parameter logic [W-1:0]  MASK = '1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] cond_i,
    input  wire logic [W-1:0] en_i,
    input  wire logic         wr_i,
    input  wire logic [W-1:0] wdata_i,
    output logic      [W-1:0] q_o
);

    typedef struct packed {
        logic [W-1:0] q;
        logic [W-1:0] seen;
    } latch_state_t;

    latch_state_t state_reg;
    latch_state_t state_next;
    logic [W-1:0] gated;
    logic [W-1:0] set_bits;
    logic [W-1:0] keep_bits;

    // set on the first cycle an enabled condition shows, so a
    // lasting state does not block a later clear
    always_comb begin
        gated      = cond_i & en_i & MASK;
        set_bits   = gated & ~state_reg.seen;
        keep_bits  = wr_i ? wdata_i : {W{1'b1}};
        state_next.seen = gated;
        // set beats clear; disabled bits drop at once
        state_next.q = ((state_reg.q & keep_bits) | set_bits)
                       & en_i & MASK;
    end

    // single state register
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_reg.q    <= '0;
            state_reg.seen <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign q_o = state_reg.q;

endmodule

//--- hdl/charger_alert_regs.sv
/*
 * Charger alert register bank: live charger state and charge status
 * indicators, sticky state and status alert registers, and the live
 * system status register; the alert and system status registers are
 * reached by command code over the serial management port.
 * Assumes the serial decoder, the charger control logic and the enable
 * registers all run on MCLK_I; none of the inputs needs synchronising.
 */
`timescale 1ns/1ps
module charger_alert_regs
    import charger_alert_pkg::*;
(
    input  wire logic                  MCLK_I,
    input  wire logic                  NRST_I,
    // command port from the serial management decoder
    input  wire logic [7:0]            CMD_I,
    input  wire logic                  WR_STB_I,
    input  wire logic [DATA_W-1:0]     WDATA_I,
    input  wire logic                  RD_STB_I,
    // charger control state, as bit index plus valid
    input  wire logic                  STATE_VALID_I,
    input  wire logic [IDX_W-1:0]      STATE_IDX_I,
    input  wire logic                  STAT_VALID_I,
    input  wire logic [STAT_IDX_W-1:0] STAT_IDX_I,
    // system conditions
    input  wire logic                  CHARGER_ACTIVE_I,
    input  wire logic                  TELEMETRY_EN_I,
    input  wire logic                  CELL_COUNT_ERR_I,
    input  wire logic [SYS_LOW_W-1:0]  SYS_LOW_I,
    // alert enables held by the enable registers
    input  wire logic [STATE_W-1:0]    STATE_ALERT_EN_I,
    input  wire logic [STATUS_W-1:0]   STATUS_ALERT_EN_I,
    // live indicators and register contents
    output logic      [STATE_W-1:0]    CHARGER_STATE_O,
    output logic      [STATUS_W-1:0]   CHARGE_STATUS_O,
    output logic      [STATE_W-1:0]    STATE_ALERT_O,
    output logic      [STATUS_W-1:0]   STATUS_ALERT_O,
    output logic      [SYS_W-1:0]      SYS_STATUS_O,
    // read answer
    output logic      [DATA_W-1:0]     RD_DATA_O,
    output logic                       RD_VALID_O
);

    // every register of the bank but the two alert registers, which sit in the latches
    typedef struct packed {
        logic [STATE_W-1:0]  live_state;
        logic [STATUS_W-1:0] live_status;
        logic [SYS_W-1:0]    sys;
        logic [DATA_W-1:0]   rd_data;
        logic                rd_valid;
    } bank_state_t;

    bank_state_t bank_reg;
    bank_state_t bank_next;

    logic [STATE_W-1:0]  state_alert;
    logic [STATUS_W-1:0] status_alert;
    logic                wr_state_alert;
    logic                wr_status_alert;

    // one-hot decode of a bit index; an index past the width gives zero
    function automatic logic [DATA_W-1:0] onehot(
        input logic       valid,
        input logic [IDX_W-1:0] idx,
        input int         width
    );
        logic [DATA_W-1:0] res;
        res = DATA_RST;
        if (valid && (int'(idx) < width)) begin
            res[idx] = 1'b1;
        end
        return res;
    endfunction

    // command code to read word; unmapped codes answer zero
    function automatic logic [DATA_W-1:0] read_word(
        input logic [7:0]          cmd,
        input logic [STATE_W-1:0]  st_alert,
        input logic [STATUS_W-1:0] sts_alert,
        input logic [SYS_W-1:0]    sys
    );
        logic [DATA_W-1:0] res;
        res = DATA_RST;
        case (cmd)
            CMD_STATE_ALERT: begin
                res[STATE_W-1:0] = st_alert;
            end
            CMD_STATUS_ALERT: begin
                res[STATUS_W-1:0] = sts_alert;
            end
            CMD_SYS_STATUS: begin
                res[SYS_W-1:0] = sys;
            end
            default: begin
                res = DATA_RST;
            end
        endcase
        return res;
    endfunction

    // write decode; the system status word is read-only, so a write
    // to it falls through and changes nothing
    assign wr_state_alert  = WR_STB_I && (CMD_I == CMD_STATE_ALERT);
    assign wr_status_alert = WR_STB_I && (CMD_I == CMD_STATUS_ALERT);

    // next-state logic of the bank
    always_comb begin
        bank_next = bank_reg;

        // live charger state: index decode keeps it one-hot by build,
        // so two states can never show together
        bank_next.live_state = STATE_W'(onehot(STATE_VALID_I,
                                               STATE_IDX_I,
                                               STATE_W));

        // live charge status only means something while charging
        if (CHARGER_ACTIVE_I) begin
            bank_next.live_status = STATUS_W'(onehot(STAT_VALID_I,
                                                     {1'b0, STAT_IDX_I},
                                                     STATUS_W));
        end else begin
            bank_next.live_status = STATUS_RST;
        end

        // live system status, sampled every cycle, never latched
        bank_next.sys[SYS_LOW_W-1:0]      = SYS_LOW_I;
        bank_next.sys[BIT_SYS_CHG_ACTIVE] = CHARGER_ACTIVE_I;
        // cell count cannot be trusted without telemetry, and
        // telemetry stops whenever the charger is off
        bank_next.sys[BIT_SYS_CELL_ERR] = CELL_COUNT_ERR_I
                                          | ~TELEMETRY_EN_I
                                          | ~CHARGER_ACTIVE_I;

        // read answer captured on the strobe, held until next read
        bank_next.rd_valid = RD_STB_I;
        if (RD_STB_I) begin
            bank_next.rd_data = read_word(CMD_I,
                                          state_alert,
                                          status_alert,
                                          bank_reg.sys);
        end
    end

    // bank register; the system status has no defined power-up value
    // but is zeroed here so the outputs are known from reset on
    always_ff @(posedge MCLK_I) begin
        if (!NRST_I) begin
            bank_reg.live_state  <= STATE_RST;
            bank_reg.live_status <= STATUS_RST;
            bank_reg.sys         <= SYS_RST;
            bank_reg.rd_data     <= DATA_RST;
            bank_reg.rd_valid    <= 1'b0;
        end else begin
            bank_reg <= bank_next;
        end
    end

    // charger state alerts; the mask leaves bits 10, 9 and 7 empty,
    // so the absorb state never raises an alert
    alert_latch #(
        .W    (STATE_W),
        .MASK (STATE_ALERT_MASK)
    ) u_state_alert (
        .clk_i   (MCLK_I),
        .rst_n_i (NRST_I),
        .cond_i  (bank_reg.live_state),
        .en_i    (STATE_ALERT_EN_I),
        .wr_i    (wr_state_alert),
        .wdata_i (WDATA_I[STATE_W-1:0]),
        .q_o     (state_alert)
    );

    // charge status alerts
    alert_latch #(
        .W    (STATUS_W),
        .MASK (STATUS_ALERT_MASK)
    ) u_status_alert (
        .clk_i   (MCLK_I),
        .rst_n_i (NRST_I),
        .cond_i  (bank_reg.live_status),
        .en_i    (STATUS_ALERT_EN_I),
        .wr_i    (wr_status_alert),
        .wdata_i (WDATA_I[STATUS_W-1:0]),
        .q_o     (status_alert)
    );

    // outputs straight from the registers
    assign CHARGER_STATE_O = bank_reg.live_state;
    assign CHARGE_STATUS_O = bank_reg.live_status;
    assign STATE_ALERT_O   = state_alert;
    assign STATUS_ALERT_O  = status_alert;
    assign SYS_STATUS_O    = bank_reg.sys;
    assign RD_DATA_O       = bank_reg.rd_data;
    assign RD_VALID_O      = bank_reg.rd_valid;

endmodule

//--- verification/charger_alert_checker.sv
/* Checker for the charger alert register bank, bound to its top module.
   Assumes one clock, MCLK_I, and synchronous active-low NRST_I. */
`timescale 1ns/1ps
module charger_alert_checker
    import charger_alert_pkg::*;
(
    input wire logic                  MCLK_I,
    input wire logic                  NRST_I,
    input wire logic                  WR_STB_I,
    input wire logic                  RD_STB_I,
    input wire logic [7:0]            CMD_I,
    input wire logic [DATA_W-1:0]     WDATA_I,
    input wire logic                  STATE_VALID_I,
    input wire logic [IDX_W-1:0]      STATE_IDX_I,
    input wire logic                  CHARGER_ACTIVE_I,
    input wire logic                  TELEMETRY_EN_I,
    input wire logic                  CELL_COUNT_ERR_I,
    input wire logic [SYS_LOW_W-1:0]  SYS_LOW_I,
    input wire logic [STATE_W-1:0]    STATE_ALERT_EN_I,
    input wire logic [STATUS_W-1:0]   STATUS_ALERT_EN_I,
    input wire logic [STATE_W-1:0]    CHARGER_STATE_O,
    input wire logic [STATUS_W-1:0]   CHARGE_STATUS_O,
    input wire logic [STATE_W-1:0]    STATE_ALERT_O,
    input wire logic [STATUS_W-1:0]   STATUS_ALERT_O,
    input wire logic [SYS_W-1:0]      SYS_STATUS_O,
    input wire logic [DATA_W-1:0]     RD_DATA_O,
    input wire logic                  RD_VALID_O
);
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (!NRST_I);
    // bits a write asks to clear; zero when no such write
    logic [STATE_W-1:0]  wclr;
    logic [STATUS_W-1:0] wclr_sts;
    logic [STATE_W-1:0]  exp_live;
    assign wclr = (WR_STB_I && CMD_I == CMD_STATE_ALERT) ?
                  ~WDATA_I[STATE_W-1:0] : '0;
    assign wclr_sts = (WR_STB_I && CMD_I == CMD_STATUS_ALERT) ?
                      ~WDATA_I[STATUS_W-1:0] : '0;
    // live state the index asks for; indices past the width give none
    assign exp_live = (STATE_VALID_I && STATE_IDX_I < STATE_W) ?
                      13'h0001 << STATE_IDX_I : '0;
    sequence s_read_state;
        RD_STB_I && CMD_I == CMD_STATE_ALERT;
    endsequence
    sequence s_read_status;
        RD_STB_I && CMD_I == CMD_STATUS_ALERT;
    endsequence
    a_read_answer: assert property (
        s_read_state |=> RD_VALID_O &&
        RD_DATA_O == {3'h0, $past(STATE_ALERT_O)})
        else $error("state alert read answer wrong");
    a_read_status: assert property (
        s_read_status |=> RD_VALID_O &&
        RD_DATA_O == {10'h000, $past(STATUS_ALERT_O)})
        else $error("status alert read answer wrong");
    a_sys_live: assert property (
        1 |=> SYS_STATUS_O == {$past(CHARGER_ACTIVE_I),
        $past(CELL_COUNT_ERR_I) | ~$past(TELEMETRY_EN_I) |
        ~$past(CHARGER_ACTIVE_I), $past(SYS_LOW_I)})
        else $error("system status word wrong");
    a_state_onehot: assert property ($onehot0(CHARGER_STATE_O))
        else $error("live charger state not one-hot");
    a_state_map: assert property (
        1 |=> CHARGER_STATE_O == $past(exp_live))
        else $error("live charger state at wrong bit");
    a_status_onehot: assert property ($onehot0(CHARGE_STATUS_O))
        else $error("live charge status not one-hot");
    a_status_off: assert property (
        !CHARGER_ACTIVE_I |=> CHARGE_STATUS_O == 6'h00)
        else $error("charge status live while charger off");
    a_disable_clears: assert property (
        1 |=> (STATE_ALERT_O & ~$past(STATE_ALERT_EN_I)) == 13'h0000 &&
        (STATUS_ALERT_O & ~$past(STATUS_ALERT_EN_I)) == 6'h00)
        else $error("disabled alert still set");
    a_unused_zero: assert property (
        (STATE_ALERT_O & ~STATE_ALERT_MASK) == 13'h0000)
        else $error("unused state alert bit set");
    a_alert_holds: assert property (
        1 |=> ($past(STATE_ALERT_O) & ~STATE_ALERT_O &
        $past(STATE_ALERT_EN_I) & ~$past(wclr)) == 13'h0000)
        else $error("state alert dropped");
    a_alert_sets: assert property (
        1 |=> ($past(CHARGER_STATE_O) & ~$past(CHARGER_STATE_O, 2) &
        $past(STATE_ALERT_EN_I) & STATE_ALERT_MASK & ~STATE_ALERT_O)
        == 13'h0000) else $error("state alert did not set");
    a_write_clears: assert property (
        1 |=> (STATE_ALERT_O & $past(wclr) &
        ~$past(CHARGER_STATE_O)) == 13'h0000)
        else $error("state alert not cleared by write");
    a_status_holds: assert property (
        1 |=> ($past(STATUS_ALERT_O) & ~STATUS_ALERT_O &
        $past(STATUS_ALERT_EN_I) & ~$past(wclr_sts)) == 6'h00)
        else $error("status alert dropped");
    a_status_sets: assert property (
        1 |=> ($past(CHARGE_STATUS_O) & ~$past(CHARGE_STATUS_O, 2) &
        $past(STATUS_ALERT_EN_I) & ~STATUS_ALERT_O) == 6'h00)
        else $error("status alert did not set");
endmodule
bind charger_alert_regs charger_alert_checker i_charger_alert_checker (.*);

//--- verification/host_port_model.sv
/* Host side of the command port: one-cycle strobes per access.
   Assumes the clock of the register bank; drives at the falling edge. */
`timescale 1ns/1ps
module host_port_model (
    input  wire logic   clk_i,
    output logic [7:0]  cmd_o,
    output logic        wr_o,
    output logic [15:0] wdata_o,
    output logic        rd_o
);
    initial begin
        cmd_o = 8'h00;
        wr_o = 1'b0;
        wdata_o = 16'h0000;
        rd_o = 1'b0;
    end
    // idle lines are scrambled so nothing relies on stale values
    task automatic access(input logic w, input logic [7:0] c,
                          input logic [15:0] d);
        @(negedge clk_i);
        cmd_o = c;
        wdata_o = d;
        wr_o = w;
        rd_o = !w;
        @(negedge clk_i);
        wr_o = 1'b0;
        rd_o = 1'b0;
        cmd_o = ~c;
        wdata_o = ~d;
    endtask
    // zero at the target bit, ones everywhere else
    task automatic clear_bit(input logic [7:0] c, input int b);
        access(1'b1, c, ~(16'h0001 << b));
    endtask
endmodule

//--- verification/charger_alert_regs_test.sv
/* Self-checking bench for the charger alert register bank.
   Assumes the host model drives the command port; reads are scored. */
`timescale 1ns/1ps
module charger_alert_regs_test;
    import charger_alert_pkg::*;
    logic mclk = 0, nrst = 0, st_valid = 0, sts_valid = 0, active = 0;
    logic tel_en = 1, cell_err = 0, wr, rd, rd_valid;
    logic [7:0] cmd;
    logic [15:0] wdata, rd_data;
    logic [3:0] st_idx = 4'h0;
    logic [2:0] sts_idx = 3'h0;
    logic [6:0] sys_low = 7'h00;
    logic [12:0] st_en = 13'h1FFF;
    logic [5:0] sts_en = 6'h3F;
    logic [31:0] r;
    logic [15:0] exp_q[$];
    int errors = 0, check_count = 0, cycles = 0, i, j;
    integer seed = 9;
    always #50 mclk = ~mclk;
    charger_alert_regs i_charger_alert_regs (.MCLK_I(mclk), .NRST_I(nrst),
        .CMD_I(cmd), .WR_STB_I(wr), .WDATA_I(wdata), .RD_STB_I(rd),
        .STATE_VALID_I(st_valid), .STATE_IDX_I(st_idx),
        .STAT_VALID_I(sts_valid), .STAT_IDX_I(sts_idx),
        .CHARGER_ACTIVE_I(active), .TELEMETRY_EN_I(tel_en),
        .CELL_COUNT_ERR_I(cell_err), .SYS_LOW_I(sys_low),
        .STATE_ALERT_EN_I(st_en), .STATUS_ALERT_EN_I(sts_en),
        .CHARGER_STATE_O(), .CHARGE_STATUS_O(), .STATE_ALERT_O(),
        .STATUS_ALERT_O(), .SYS_STATUS_O(), .RD_DATA_O(rd_data),
        .RD_VALID_O(rd_valid));
    host_port_model i_host_port_model (.clk_i(mclk), .cmd_o(cmd), .wr_o(wr),
        .wdata_o(wdata), .rd_o(rd));
    task automatic report_and_stop;
        $display("errors %0d check_count %0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // note the expected answer, then issue the read
    task automatic rd_exp(input logic [7:0] c, input logic [15:0] e);
        exp_q.push_back(e);
        i_host_port_model.access(1'b0, c, 16'h0000);
    endtask
    // scoring: oldest note against each answer
    always @(negedge mclk) begin
        if (rd_valid === 1'b1) begin
            check_count++;
            if (exp_q.size() == 0 || rd_data !== exp_q[0]) begin
                errors++;
                $display("BAD read expected %h seen %h", exp_q[0], rd_data);
            end
            if (exp_q.size() > 0)
                void'(exp_q.pop_front());
        end
    end
    // hang guard, well above the roughly 150 cycles used
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            report_and_stop();
        end
    end
    initial begin
        repeat (5) @(negedge mclk);
        nrst = 1;
        rd_exp(CMD_STATE_ALERT, 16'h0000);
        rd_exp(CMD_STATUS_ALERT, 16'h0000);
        rd_exp(CMD_SYS_STATUS, 16'h0080);
        rd_exp(8'h40, 16'h0000);
        // walk every state index, including ones with no alert
        for (i = 0; i < 13; i++) begin
            st_idx = i[3:0];
            st_valid = 1;
            repeat (3) @(negedge mclk);
        end
        rd_exp(CMD_STATE_ALERT, {3'h0, STATE_ALERT_MASK});
        i_host_port_model.clear_bit(CMD_STATE_ALERT, 0);
        i_host_port_model.clear_bit(CMD_STATE_ALERT, 12);
        rd_exp(CMD_STATE_ALERT, 16'h097E);
        st_en[11] = 0;
        st_en[5] = 0;
        st_idx = 4'h5;
        repeat (3) @(negedge mclk);
        rd_exp(CMD_STATE_ALERT, 16'h015E);
        // state 4 rises in the very cycle a clear of bit 4 lands
        st_idx = 4'h4;
        i_host_port_model.clear_bit(CMD_STATE_ALERT, 4);
        rd_exp(CMD_STATE_ALERT, 16'h015E);
        // status alerts: first with charger off, then on
        for (j = 0; j < 2; j++) begin
            active = j[0];
            for (i = 0; i < 6; i++) begin
                sts_idx = i[2:0];
                sts_valid = 1;
                repeat (3) @(negedge mclk);
            end
            rd_exp(CMD_STATUS_ALERT, j ? 16'h003F : 16'h0000);
        end
        i_host_port_model.clear_bit(CMD_STATUS_ALERT, 5);
        sts_en[0] = 0;
        rd_exp(CMD_STATUS_ALERT, 16'h001E);
        // random live conditions; writes to the status code are ignored
        for (i = 0; i < 8; i++) begin
            r = $random(seed);
            {active, tel_en, cell_err, sys_low} = r[9:0];
            i_host_port_model.access(1'b1, CMD_SYS_STATUS, r[31:16]);
            rd_exp(CMD_SYS_STATUS, {7'h00, active,
                cell_err | ~tel_en | ~active, sys_low});
        end
        // the writes to the read-only code left the state alerts alone
        rd_exp(CMD_STATE_ALERT, 16'h015E);
        repeat (4) @(negedge mclk);
        if (exp_q.size() != 0) begin
            errors++;
            $display("BAD answers expected %0d seen 0", exp_q.size());
        end
        report_and_stop();
    end
endmodule
